// [shared/sbr_pkg.sv]
// package: register map, bit layout and reset values of the side-band enable readback bank
package sbr_pkg;

  // number of gated differential outputs (7 fast, 9 mux, 3 slow, 1 platform)
  localparam int unsigned OUT_COUNT = 20;

  // positions inside the flat per-output vector
  localparam int unsigned FAST_LSB = 0;   // fast_clock_output 6..0
  localparam int unsigned FAST_COUNT = 7;
  localparam int unsigned MUX_LSB = 7;    // selectable_rate_output 8..0
  localparam int unsigned MUX_HI_BIT = 15; // selectable_rate_output 8
  localparam int unsigned SLOW_LSB = 16;  // slow_clock_output 2..0
  localparam int unsigned PLAT_BIT = 19;  // platform_time_output

  // byte offsets of the register port
  localparam logic [7:0] ADDR_MASK_HI_SPEED = 8'h0b;
  localparam logic [7:0] ADDR_MASK_MUX = 8'h0c;
  localparam logic [7:0] ADDR_MASK_LOW_SPEED = 8'h0d;
  localparam logic [7:0] ADDR_RB_HI_SPEED = 8'h0e;
  localparam logic [7:0] ADDR_RB_MUX = 8'h0f;
  localparam logic [7:0] ADDR_RB_LOW_SPEED = 8'h10;
  localparam logic [7:0] ADDR_PT_BYPASS = 8'h31;

  // group selectors used by the byte pack and merge functions
  localparam logic [1:0] GRP_HI_SPEED = 2'h0;
  localparam logic [1:0] GRP_MUX = 2'h1;
  localparam logic [1:0] GRP_LOW_SPEED = 2'h2;

  // reset values
  localparam logic [19:0] RB_RESET = 20'hfffff;  // every output reads enabled
  localparam logic [19:0] MASK_RESET = 20'h00000; // side-band may disable
  localparam logic [7:0] PT_BYPASS_FIXED = 8'h94; // reserved bits as powered up
  localparam logic PT_BYPASS_RESET = 1'b0;        // normal platform-time mode
  localparam int unsigned PT_BYPASS_BIT = 0;

  // one register-port request from the serial management engine
  typedef struct packed {
    logic [7:0] addr;  // register byte offset
    logic wr;          // one-cycle write strobe
    logic rd;          // one-cycle read strobe
    logic [7:0] wdata; // write byte
  } sbr_req_type;

  // side-band shift/load capture
  typedef struct packed {
    logic load;        // one-cycle load strobe
    logic [19:0] data; // parallel shift-register contents, flat layout
  } sbr_sb_type;

endpackage : sbr_pkg

// [hw/sbr_gate.sv]
// per-output enable gating from side-band state, mask, management enable and pins
`timescale 1ns/1ps
`default_nettype none
module sbr_gate
  import sbr_pkg::*;
(
  input wire logic [19:0] captured,
  input wire logic [19:0] mask,
  input wire logic [19:0] smb_oe,
  input wire logic [6:0] oe_n,
  output logic [19:0] enable
);

  // pin term: only fast outputs have an active-low pin, others pass
  wire [19:0] pin_ok;
  // side-band term: masked outputs ignore the captured value
  wire [19:0] sb_ok;

  assign pin_ok = {{(OUT_COUNT - FAST_COUNT){1'b1}}, ~oe_n};
  assign sb_ok = captured | mask;
  assign enable = sb_ok & smb_oe & pin_ok;

endmodule : sbr_gate
`default_nettype wire

// [hw/sbr_core.sv]
// side-band enable readback, mask and platform-time bypass register bank
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - load strobe captures shift register into readback
// - captured zero disables output unless masked
// - captured one needs management enable, pin low
// - cleared mask lets side-band disable output
// - set mask: only enable bit, pin disable
// - readback bytes follow fixed output bit layout
// - readback read-only, powers up all ones
// - bypass bit zero read/write, resets to zero
// - three mask registers, same layout, reset zero
module sbr_core
  import sbr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire sbr_req_type req,
  input wire sbr_sb_type sb,
  input wire logic [19:0] smb_oe,
  input wire logic [6:0] oe_n,
  output logic [7:0] rdata,
  output logic [19:0] out_enable,
  output logic pt_bypass
);

  // pack one register byte out of the flat per-output vector
  function automatic logic [7:0] pack_byte(input logic [19:0] v, input logic [1:0] grp);
    logic [7:0] b;
    b = 8'h00;
    if (grp == GRP_HI_SPEED)
      b = {v[MUX_HI_BIT], v[FAST_LSB +: FAST_COUNT]};
    else if (grp == GRP_MUX)
      b = v[MUX_LSB +: 8];
    else if (grp == GRP_LOW_SPEED)
      b = {4'h0, v[PLAT_BIT], v[SLOW_LSB +: 3]}; // reserved high nibble is zero
    return b;
  endfunction : pack_byte

  // merge one written byte into the flat vector, reserved bits dropped
  function automatic logic [19:0] merge_byte(input logic [19:0] v, input logic [1:0] grp,
                                             input logic [7:0] b);
    logic [19:0] r;
    r = v;
    if (grp == GRP_HI_SPEED)
    begin
      r[MUX_HI_BIT] = b[7];
      r[FAST_LSB +: FAST_COUNT] = b[6:0];
    end
    else if (grp == GRP_MUX)
      r[MUX_LSB +: 8] = b;
    else if (grp == GRP_LOW_SPEED)
      r[SLOW_LSB +: 4] = b[3:0];
    return r;
  endfunction : merge_byte

  // captured side-band state, one bit per output
  logic [19:0] captured;
  // side-band mask bits, one per output
  logic [19:0] mask;
  // next values
  logic [19:0] next_mask;
  logic [7:0] next_rdata;
  // gated enables before the output flop
  logic [19:0] gated;

  // write decode
  wire wr_mask_hi = req.wr && (req.addr == ADDR_MASK_HI_SPEED);
  wire wr_mask_mux = req.wr && (req.addr == ADDR_MASK_MUX);
  wire wr_mask_lo = req.wr && (req.addr == ADDR_MASK_LOW_SPEED);
  wire wr_bypass = req.wr && (req.addr == ADDR_PT_BYPASS);

  // mask write merge; readback offsets are not decoded for writes, so they stay read-only
  always_comb
  begin
    next_mask = mask;
    if (wr_mask_hi)
      next_mask = merge_byte(mask, GRP_HI_SPEED, req.wdata);
    else if (wr_mask_mux)
      next_mask = merge_byte(mask, GRP_MUX, req.wdata);
    else if (wr_mask_lo)
      next_mask = merge_byte(mask, GRP_LOW_SPEED, req.wdata);
  end

  // read decode; unmapped offsets answer zero
  always_comb
  begin
    next_rdata = rdata;
    if (!req.rd)
      next_rdata = rdata;
    else if (req.addr == ADDR_MASK_HI_SPEED)
      next_rdata = pack_byte(mask, GRP_HI_SPEED);
    else if (req.addr == ADDR_MASK_MUX)
      next_rdata = pack_byte(mask, GRP_MUX);
    else if (req.addr == ADDR_MASK_LOW_SPEED)
      next_rdata = pack_byte(mask, GRP_LOW_SPEED);
    else if (req.addr == ADDR_RB_HI_SPEED)
      next_rdata = pack_byte(captured, GRP_HI_SPEED);
    else if (req.addr == ADDR_RB_MUX)
      next_rdata = pack_byte(captured, GRP_MUX);
    else if (req.addr == ADDR_RB_LOW_SPEED)
      next_rdata = pack_byte(captured, GRP_LOW_SPEED);
    else if (req.addr == ADDR_PT_BYPASS)
      next_rdata = PT_BYPASS_FIXED | {7'h00, pt_bypass};
    else
      next_rdata = 8'h00;
  end

  // gating of each output from side-band, mask, management bit and pin
  sbr_gate u_gate (
    .captured(captured),
    .mask(mask),
    .smb_oe(smb_oe),
    .oe_n(oe_n),
    .enable(gated)
  );

  // side-band capture; reset shows every output enabled until a first load
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      captured <= RB_RESET;
    else if (sb.load)
      captured <= sb.data;
  end

  // mask registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mask <= MASK_RESET;
    else
      mask <= next_mask;
  end

  // bypass bit; reserved bits are constants, so writes to them have no effect
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pt_bypass <= PT_BYPASS_RESET;
    else if (wr_bypass)
      pt_bypass <= req.wdata[PT_BYPASS_BIT];
  end

  // registered read data and enables; enables lag captured state by one cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
      out_enable <= '0;
    end
    else
    begin
      rdata <= next_rdata;
      out_enable <= gated;
    end
  end

  // checks on the bank's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_load;
    sb.load;
  endsequence

  sequence s_rd_hi;
    req.rd && (req.addr == ADDR_RB_HI_SPEED);
  endsequence

  sequence s_rd_lo;
    req.rd && (req.addr == ADDR_RB_LOW_SPEED);
  endsequence

  a_capture_load: assert property (s_load |=> captured == $past(sb.data))
    else $error("side-band load not captured");

  a_rb_read_only: assert property (!sb.load |=> $stable(captured))
    else $error("readback changed without a load");

  a_zero_disables: assert property (1'b1 |=>
      ((out_enable & ~($past(captured) | $past(mask))) == 20'h00000))
    else $error("unmasked zero left an output enabled");

  a_one_needs_enable: assert property (1'b1 |=>
      ((out_enable & ~$past(smb_oe)) == 20'h00000 &&
       (out_enable[6:0] & $past(oe_n)) == 7'h00))
    else $error("output enabled without enable bit or pin");

  a_mask_keeps_on: assert property (1'b1 |=>
      ((~out_enable & $past(mask) & $past(smb_oe) &
        {13'h1fff, ~$past(oe_n)}) == 20'h00000))
    else $error("masked output disabled by side-band");

  a_rb_layout_hi: assert property (s_rd_hi |=>
      rdata == {$past(captured[15]), $past(captured[6:0])})
    else $error("readback byte layout wrong");

  a_rb_layout_lo: assert property (s_rd_lo |=>
      rdata == {4'h0, $past(captured[19:16])})
    else $error("low-speed readback layout wrong");

  a_reset_enabled: assert property ($past(rst) |-> captured == 20'hfffff && !pt_bypass)
    else $error("readback not all enabled after reset");

  a_bypass_write: assert property (wr_bypass |=> pt_bypass == $past(req.wdata[0]))
    else $error("bypass bit write lost");

  a_mask_write: assert property (wr_mask_mux |=> mask[14:7] == $past(req.wdata))
    else $error("mask write lost");

  a_mask_write_lo: assert property (wr_mask_lo |=> mask[19:16] == $past(req.wdata[3:0]))
    else $error("low-speed mask write lost");

  a_bypass_reserved: assert property (req.rd && (req.addr == ADDR_PT_BYPASS) |=>
      rdata[7:1] == 7'h4a)
    else $error("bypass reserved bits changed");

endmodule : sbr_core
`default_nettype wire

// [verification/sbr_host_model.sv]
// stand-in for the management host and side-band shift/load controller
`timescale 1ns/1ps
`default_nettype none
module sbr_host_model
  import sbr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output var sbr_req_type req,
  output var sbr_sb_type sb
);
  // idle: no strobes
  initial
  begin
    req = '0;
    sb = '0;
  end
  // one byte write, launched on the falling edge, held across one rising edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge mclk);
    req.wr = 1'b0;
  endtask : reg_wr
  // one byte read; data is settled one edge after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~a};
    @(negedge mclk);
    req.rd = 1'b0;
    d = rdata;
  endtask : reg_rd
  // parallel load; data is inverted after the strobe so a stray capture shows
  task automatic sb_load(input logic [19:0] v);
    @(negedge mclk);
    sb = '{load: 1'b1, data: v};
    @(negedge mclk);
    sb = '{load: 1'b0, data: ~v};
  endtask : sb_load
endmodule : sbr_host_model
`default_nettype wire

// [verification/sideband_enable_readback_tb_top.sv]
// self-checking bench for the side-band enable readback bank
`timescale 1ns/1ps
`default_nettype none
module sideband_enable_readback_tb_top
  import sbr_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] smb_oe = 20'hfffff; // management enables
  logic [6:0] oe_n = 7'h00; // fast pins, low enables
  logic [7:0] rdata;
  logic [19:0] out_enable;
  logic pt_bypass;
  sbr_req_type req;
  sbr_sb_type sb;
  int n_fail = 0;
  int n_checks = 0;
  logic [19:0] cap; // bench copy of the captured word
  logic [19:0] msk; // bench copy of the masks
  // 10 MHz clock
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  sbr_host_model host (.mclk(mclk), .rdata(rdata), .req(req), .sb(sb));
  sbr_core DUT (.mclk(mclk), .rst(rst), .req(req), .sb(sb), .smb_oe(smb_oe),
    .oe_n(oe_n), .rdata(rdata), .out_enable(out_enable), .pt_bypass(pt_bypass));
  // register byte of one group taken from a flat vector
  function automatic logic [7:0] pack(input int g, input logic [19:0] v);
    if (g == 0)
      return {v[15], v[6:0]};
    if (g == 1)
      return v[14:7];
    return {4'h0, v[19:16]};
  endfunction : pack
  // expected gating; only the seven fast outputs have pins
  function automatic logic [19:0] gate(input logic [19:0] c, m, s, input logic [6:0] n);
    return (c | m) & s & {13'h1fff, ~n};
  endfunction : gate
  // byte result compare
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  // enable vector compare
  task automatic chk_en(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t enables %h expected %h", $time, got, exp);
    end
  endtask : chk_en
  // read one register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.reg_rd(a, d);
    chk_byte(d, exp);
  endtask : rd_chk
  // counts and verdict
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    void'($urandom(17));
    cap = 20'hfffff;
    msk = 20'h00000;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    for (int g = 0; g < 3; g++)
    begin
      rd_chk(ADDR_RB_HI_SPEED + 8'(g), pack(g, cap));
      rd_chk(ADDR_MASK_HI_SPEED + 8'(g), 8'h00);
    end
    rd_chk(ADDR_PT_BYPASS, 8'h94);
    chk_en(out_enable, gate(cap, msk, smb_oe, oe_n));
    // read-only place, unmapped place, bypass bit and its reserved neighbours
    host.reg_wr(ADDR_RB_MUX, 8'h00);
    rd_chk(ADDR_RB_MUX, 8'hff);
    rd_chk(8'h20, 8'h00);
    host.reg_wr(ADDR_PT_BYPASS, 8'hff);
    rd_chk(ADDR_PT_BYPASS, 8'h95);
    chk_byte({7'h0, pt_bypass}, 8'h01);
    host.reg_wr(ADDR_PT_BYPASS, 8'h00);
    rd_chk(ADDR_PT_BYPASS, 8'h94);
    chk_byte({7'h0, pt_bypass}, 8'h00);
    // first pass: all masked with zero side-band; second: no management enables
    for (int i = 0; i < 40; i++)
    begin
      cap = (i == 0) ? 20'h00000 : 20'($urandom());
      msk = (i == 0) ? 20'hfffff : 20'($urandom());
      @(negedge mclk);
      smb_oe = (i == 1) ? 20'h00000 : 20'($urandom());
      oe_n = 7'($urandom());
      host.sb_load(cap);
      for (int g = 0; g < 3; g++)
        host.reg_wr(ADDR_MASK_HI_SPEED + 8'(g), pack(g, msk));
      repeat (3) @(negedge mclk);
      chk_en(out_enable, gate(cap, msk, smb_oe, oe_n));
      for (int g = 0; g < 3; g++)
      begin
        rd_chk(ADDR_RB_HI_SPEED + 8'(g), pack(g, cap));
        rd_chk(ADDR_MASK_HI_SPEED + 8'(g), pack(g, msk));
      end
    end
    // mid-run reset with the bypass set must bring back the power-up view
    host.reg_wr(ADDR_PT_BYPASS, 8'h01);
    @(negedge mclk);
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    cap = 20'hfffff;
    msk = 20'h00000;
    for (int g = 0; g < 3; g++)
    begin
      rd_chk(ADDR_RB_HI_SPEED + 8'(g), pack(g, cap));
      rd_chk(ADDR_MASK_HI_SPEED + 8'(g), 8'h00);
    end
    rd_chk(ADDR_PT_BYPASS, 8'h94);
    chk_byte({7'h0, pt_bypass}, 8'h00);
    chk_en(out_enable, gate(cap, msk, smb_oe, oe_n));
    final_report();
  end
endmodule : sideband_enable_readback_tb_top
`default_nettype wire
